// [src/mspc_defines.svh]
// Offsets, field positions, reset values and counts of the PCS status bank
`ifndef MSPC_DEFINES_SVH
`define MSPC_DEFINES_SVH

// ----------------------------------------
// Bus widths and register offsets
// ----------------------------------------
`define MSPC_ADDR_W      5
`define MSPC_DATA_W      16
`define MSPC_OFS_CTRL    5'h17
`define MSPC_OFS_PCS     5'h18
`define MSPC_OFS_ADV     5'h19
`define MSPC_OFS_LP      5'h1A
`define MSPC_OFS_SDS     5'h1B
`define MSPC_OFS_GOOD    5'h1C
`define MSPC_OFS_CRC     5'h1D

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MSPC_CTRL_FORCE  11
`define MSPC_PCS_SYNC    15
`define MSPC_PCS_CGBAD   14
`define MSPC_PCS_PT100   13
`define MSPC_PCS_PT10    12
`define MSPC_PCS_ANRST   11
`define MSPC_PCS_RF_HI   9
`define MSPC_PCS_RF_LO   8
`define MSPC_PCS_ASYM    7
`define MSPC_PCS_SYM     6
`define MSPC_PCS_FD      5
`define MSPC_PCS_HD      4
`define MSPC_PCS_LPAN    3
`define MSPC_PCS_LINK    2
`define MSPC_PCS_ANDONE  1
`define MSPC_PCS_SIGDET  0
`define MSPC_SDS_ALIGN   15
`define MSPC_SDS_SIGDET  14
`define MSPC_SDS_FAR_END_FAULT_INDICATION    13
`define MSPC_SDS_COMMA   12
`define MSPC_SDS_POS_HI  11
`define MSPC_SDS_POS_LO  8
`define MSPC_SDS_HLS     7
`define MSPC_GOOD_ACT    15
`define MSPC_GOOD_CNT_HI 13
`define MSPC_CRC_SEL_HI  15
`define MSPC_CRC_SEL_LO  14
`define MSPC_CRC_CNT_HI  7
`define MSPC_CW_FD       5
`define MSPC_CW_HD       6
`define MSPC_CW_SYM      7
`define MSPC_CW_ASYM     8
`define MSPC_CW_RF_HI    13
`define MSPC_CW_RF_LO    12

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define MSPC_ADV_RST     16'h0000
`define MSPC_LP_RST      16'h0000
`define MSPC_COMMA_RST   1'b1
`define MSPC_GOOD_MOD    10000
`define MSPC_CRC_MAX     8'hFF

`endif

// [src/mspc_pkg.sv]
// Carrier types and select codes of the PCS status bank
package mspc_pkg;

	// ----------------------------------------
	// One-cycle events from the PCS
	// ----------------------------------------
	typedef struct packed {
		logic sync_lost;
		logic code_group_bad;
		logic an_restart;
		logic realign;
		logic far_end_fault_indication;
		logic halt_line_state;
	} mspc_evt_t;

	// ----------------------------------------
	// Levels from the PCS
	// ----------------------------------------
	typedef struct packed {
		logic       pt_mode;
		logic       pt_link_100;
		logic       pt_link_10;
		logic       partner_an_able;
		logic       link_up;
		logic       an_done;
		logic       sig_det;
		logic       comma_det;
		logic [3:0] comma_pos;
	} mspc_lvl_t;

	// ----------------------------------------
	// Packet pulses per source
	// ----------------------------------------
	typedef struct packed {
		logic media_good;
		logic media_crc_err;
		logic mac_good;
		logic mac_crc_err;
	} mspc_pkt_t;

	typedef enum logic [1:0] {
		MSPC_SEL_MEDIA = 2'h0,
		MSPC_SEL_MAC   = 2'h1
	} mspc_sel_t;

endpackage

// [src/mspc_status_counters.sv]
// PCS status, code word and receive counter register bank
//
// Behaviour
// - Sync-lost sticky flag at PCS status bit 15, cleared by reading.
// - Invalid code-group sticky flag at bit 14, cleared by reading.
// - Bits 13 and 12 show 100 Mb and 10 Mb link in transfer mode.
// - Bit 11 set when partner requests auto-negotiation restart.
// - Bits 9:8 carry partner remote fault; nonzero means fault.
// - Bits 7 and 6 show partner asymmetric and symmetric pause.
// - Bits 5 and 4 show partner full and half duplex.
// - Bits 3..0: partner AN able, link, AN done, signal detect.
// - Advertised word resets to zero, writable only when force bit set.
// - Advertised word reads undefined in transfer mode without force.
// - Partner word holds last received configuration code word, read only.
// - SerDes status bit 15 sticky on comma re-alignment, read clears.
// - Bit 14 sticky signal detect, cleared by reading.
// - Bit 13 set on far-end fault since previous read.
// - Comma detect bit 12 drops without comma, back to one on read.
// - Bits 11:8 give comma alignment position 0 to 9.
// - Bit 7 set on halt line state since previous read.
// - Good counter bit 15 flags packet since last read, read clears.
// - 14-bit good counter wraps to zero on reaching 10000.
// - Select field 15:14: 00 media, 01 MAC, others reserved.
// - 8-bit CRC error counter saturates, read clears, restarts.
// - Receive counters run only while media link is up.
// - Control bit 11 forces the advertised word into use.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mspc_defines.svh"

module mspc_status_counters (
	// Clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_n_i,
	// Register port
	input  wire logic [`MSPC_ADDR_W-1:0]  addr_i,
	input  wire logic [`MSPC_DATA_W-1:0]  wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic      [`MSPC_DATA_W-1:0]  rdata_o,
	// PCS side, same clock
	input  wire mspc_pkg::mspc_evt_t      evt_i,
	input  wire mspc_pkg::mspc_lvl_t      lvl_i,
	input  wire mspc_pkg::mspc_pkt_t      pkt_i,
	input  wire logic [`MSPC_DATA_W-1:0]  rx_cfg_word_i,
	input  wire logic                     rx_cfg_valid_i,
	// Advertised ability to the PCS
	output logic      [`MSPC_DATA_W-1:0]  adv_word_o,
	output logic                          force_adv_o
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [`MSPC_DATA_W-1:0]     lp_word;
	logic [`MSPC_DATA_W-1:0]     next_lp_word;
	logic [`MSPC_DATA_W-1:0]     next_adv_word;
	logic                        next_force_adv;
	logic [7:0]                  sticky;
	logic [7:0]                  next_sticky;
	logic [7:0]                  st_set;
	logic [7:0]                  st_clr;
	logic                        comma_q;
	logic                        next_comma;
	logic [1:0]                  rx_sel;
	logic [1:0]                  next_rx_sel;
	logic [`MSPC_GOOD_CNT_HI:0]  good_cnt;
	logic [`MSPC_GOOD_CNT_HI:0]  next_good_cnt;
	logic [`MSPC_CRC_CNT_HI:0]   crc_cnt;
	logic [`MSPC_CRC_CNT_HI:0]   next_crc_cnt;
	logic [`MSPC_CRC_CNT_HI:0]   crc_base;
	logic [`MSPC_DATA_W-1:0]     pcs_word;
	logic [`MSPC_DATA_W-1:0]     sds_word;
	logic [`MSPC_DATA_W-1:0]     good_word;
	logic [`MSPC_DATA_W-1:0]     crc_word;
	logic [`MSPC_DATA_W-1:0]     ctrl_word;
	logic [`MSPC_DATA_W-1:0]     adv_rd_word;
	logic [`MSPC_DATA_W-1:0]     rd_mux;
	logic [`MSPC_DATA_W-1:0]     next_rdata;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire logic sel_ctrl = addr_i == `MSPC_OFS_CTRL;
	wire logic sel_pcs  = addr_i == `MSPC_OFS_PCS;
	wire logic sel_adv  = addr_i == `MSPC_OFS_ADV;
	wire logic sel_lp   = addr_i == `MSPC_OFS_LP;
	wire logic sel_sds  = addr_i == `MSPC_OFS_SDS;
	wire logic sel_good = addr_i == `MSPC_OFS_GOOD;
	wire logic sel_crc  = addr_i == `MSPC_OFS_CRC;

	wire logic rd_pcs   = rd_i && sel_pcs;
	wire logic rd_sds   = rd_i && sel_sds;
	wire logic rd_good  = rd_i && sel_good;
	wire logic rd_crc   = rd_i && sel_crc;
	wire logic wr_ctrl  = wr_i && sel_ctrl;
	wire logic wr_crc   = wr_i && sel_crc;
	wire logic wr_adv   = wr_i && sel_adv && force_adv_o;

	// ----------------------------------------
	// Control and advertised word
	// ----------------------------------------
	// force advertised
	assign next_force_adv = wr_ctrl ? wdata_i[`MSPC_CTRL_FORCE] : force_adv_o;
	assign next_adv_word  = wr_adv ? wdata_i : adv_word_o;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			force_adv_o <= 1'b0;
			adv_word_o  <= `MSPC_ADV_RST;
		end else begin
			force_adv_o <= next_force_adv;
			adv_word_o  <= next_adv_word;
		end
	end

	// ----------------------------------------
	// Partner code word
	// ----------------------------------------
	// latch received word
	assign next_lp_word = rx_cfg_valid_i ? rx_cfg_word_i : lp_word;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lp_word <= `MSPC_LP_RST;
		end else begin
			lp_word <= next_lp_word;
		end
	end

	// ----------------------------------------
	// Sticky flags
	// ----------------------------------------
	// Order: sync, cgbad, anrst, align, sigdet, far_end_fault_indication, hls, pkt
	wire logic f_sync;
	wire logic f_cgbad;
	wire logic f_anrst;
	wire logic f_align;
	wire logic f_sigdet;
	wire logic f_far_end_fault_indication;
	wire logic f_hls;
	wire logic f_pkt;
	wire logic good_inc;
	wire logic crc_inc;

	assign st_set = {evt_i.sync_lost, evt_i.code_group_bad,
		evt_i.an_restart, evt_i.realign, lvl_i.sig_det,
		evt_i.far_end_fault_indication, evt_i.halt_line_state,
		good_inc};
	assign st_clr = {rd_pcs, rd_pcs, rd_pcs, rd_sds,
		rd_sds, rd_sds, rd_sds, rd_good};
	assign next_sticky = st_set | (sticky & ~st_clr);
	assign {f_sync, f_cgbad, f_anrst, f_align,
		f_sigdet, f_far_end_fault_indication, f_hls, f_pkt} = sticky;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sticky <= 8'h00;
		end else begin
			sticky <= next_sticky;
		end
	end

	// ----------------------------------------
	// Comma detect
	// ----------------------------------------
	// loss of comma wins over read restore
	assign next_comma = !lvl_i.comma_det ? 1'b0 :
		rd_sds ? 1'b1 : comma_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			comma_q <= `MSPC_COMMA_RST;
		end else begin
			comma_q <= next_comma;
		end
	end

	// ----------------------------------------
	// Receive counters
	// ----------------------------------------
	// source select, reserved codes count nothing
	wire logic src_media = rx_sel == mspc_pkg::MSPC_SEL_MEDIA;
	wire logic src_mac   = rx_sel == mspc_pkg::MSPC_SEL_MAC;
	assign next_rx_sel = wr_crc ?
		wdata_i[`MSPC_CRC_SEL_HI:`MSPC_CRC_SEL_LO] : rx_sel;

	assign good_inc = lvl_i.link_up &&
		((src_media && pkt_i.media_good) || (src_mac && pkt_i.mac_good));
	assign crc_inc = lvl_i.link_up &&
		((src_media && pkt_i.media_crc_err) ||
		(src_mac && pkt_i.mac_crc_err));

	wire logic good_wrap = good_cnt ==
		(`MSPC_GOOD_CNT_HI+1)'(`MSPC_GOOD_MOD - 1);
	assign next_good_cnt = !good_inc ? good_cnt :
		good_wrap ? '0 : good_cnt + 1'b1;

	// clear on read, then count; hold at maximum
	assign crc_base = rd_crc ? '0 : crc_cnt;
	assign next_crc_cnt = (crc_inc && crc_base != `MSPC_CRC_MAX) ?
		crc_base + 1'b1 : crc_base;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_sel   <= 2'h0;
			good_cnt <= '0;
			crc_cnt  <= '0;
		end else begin
			rx_sel   <= next_rx_sel;
			good_cnt <= next_good_cnt;
			crc_cnt  <= next_crc_cnt;
		end
	end

	// ----------------------------------------
	// Read words
	// ----------------------------------------
	// Reserved bits stay at zero from the defaults below
	always_comb begin
		pcs_word = '0;
		pcs_word[`MSPC_PCS_SYNC]   = f_sync;
		pcs_word[`MSPC_PCS_CGBAD]  = f_cgbad;
		pcs_word[`MSPC_PCS_PT100]  = lvl_i.pt_mode && lvl_i.pt_link_100;
		pcs_word[`MSPC_PCS_PT10]   = lvl_i.pt_mode && lvl_i.pt_link_10;
		pcs_word[`MSPC_PCS_ANRST]  = f_anrst;
		pcs_word[`MSPC_PCS_RF_HI:`MSPC_PCS_RF_LO] =
			lp_word[`MSPC_CW_RF_HI:`MSPC_CW_RF_LO];
		pcs_word[`MSPC_PCS_ASYM]   = lp_word[`MSPC_CW_ASYM];
		pcs_word[`MSPC_PCS_SYM]    = lp_word[`MSPC_CW_SYM];
		pcs_word[`MSPC_PCS_FD]     = lp_word[`MSPC_CW_FD];
		pcs_word[`MSPC_PCS_HD]     = lp_word[`MSPC_CW_HD];
		pcs_word[`MSPC_PCS_LPAN]   = lvl_i.partner_an_able;
		pcs_word[`MSPC_PCS_LINK]   = lvl_i.link_up;
		pcs_word[`MSPC_PCS_ANDONE] = lvl_i.an_done;
		pcs_word[`MSPC_PCS_SIGDET] = lvl_i.sig_det;
	end

	always_comb begin
		sds_word = '0;
		sds_word[`MSPC_SDS_ALIGN]  = f_align;
		sds_word[`MSPC_SDS_SIGDET] = f_sigdet;
		sds_word[`MSPC_SDS_FAR_END_FAULT_INDICATION]   = f_far_end_fault_indication;
		sds_word[`MSPC_SDS_COMMA]  = comma_q;
		sds_word[`MSPC_SDS_POS_HI:`MSPC_SDS_POS_LO] = lvl_i.comma_pos;
		sds_word[`MSPC_SDS_HLS]    = f_hls;
	end

	always_comb begin
		good_word = '0;
		good_word[`MSPC_GOOD_ACT] = f_pkt;
		good_word[`MSPC_GOOD_CNT_HI:0] = good_cnt;
		crc_word = '0;
		crc_word[`MSPC_CRC_SEL_HI:`MSPC_CRC_SEL_LO] = rx_sel;
		crc_word[`MSPC_CRC_CNT_HI:0] = crc_cnt;
		ctrl_word = '0;
		ctrl_word[`MSPC_CTRL_FORCE] = force_adv_o;
	end

	// undefined case reads zero so software never sees stale data
	assign adv_rd_word = (lvl_i.pt_mode && !force_adv_o) ? '0 : adv_word_o;

	assign rd_mux = sel_pcs  ? pcs_word :
		sel_adv  ? adv_rd_word :
		sel_lp   ? lp_word :
		sel_sds  ? sds_word :
		sel_good ? good_word :
		sel_crc  ? crc_word :
		sel_ctrl ? ctrl_word : '0;

	// Read data stand only in the cycle after the strobe
	assign next_rdata = rd_i ? rd_mux : '0;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_rd_pcs;
		rd_i && addr_i == `MSPC_OFS_PCS;
	endsequence

	sequence s_rd_sds;
		rd_i && addr_i == `MSPC_OFS_SDS;
	endsequence

	sequence s_quiet_cgbad;
		rd_pcs && !evt_i.code_group_bad;
	endsequence

	// Held from the event until a read takes it
	a_sync_held: assert property (
		(evt_i.sync_lost || (f_sync && !rd_pcs)) |=> f_sync)
		else $error("sync flag lost before read");

	a_cgbad_clears: assert property (
		s_quiet_cgbad |=> !f_cgbad)
		else $error("code-group flag not cleared by read");

	a_rf_field: assert property (
		s_rd_pcs |=> rdata_o[`MSPC_PCS_RF_HI:`MSPC_PCS_RF_LO] ==
			$past(lp_word[`MSPC_CW_RF_HI:`MSPC_CW_RF_LO]))
		else $error("remote fault field mismatch");

	a_adv_locked: assert property (
		(wr_i && sel_adv && !force_adv_o) |=> $stable(adv_word_o))
		else $error("advertised word changed while locked");

	a_adv_forced: assert property (
		(wr_i && sel_adv && force_adv_o) |=> adv_word_o == $past(wdata_i))
		else $error("forced advertised write not taken");

	a_comma_drop: assert property (
		!lvl_i.comma_det |=> !comma_q)
		else $error("comma detect not dropped");

	a_good_wrap: assert property (
		(good_inc && good_wrap) |=> good_cnt == '0)
		else $error("good counter did not wrap");

	a_crc_sat: assert property (
		(crc_inc && !rd_crc && crc_cnt == `MSPC_CRC_MAX) |=>
			crc_cnt == `MSPC_CRC_MAX)
		else $error("crc counter did not saturate");

	a_link_gate: assert property (
		(!lvl_i.link_up && !rd_crc) |=>
			$stable(good_cnt) && $stable(crc_cnt))
		else $error("counter moved with link down");

	a_resv_zero: assert property (
		s_rd_sds |=> rdata_o[`MSPC_SDS_HLS-1:0] == '0)
		else $error("reserved bits not zero");

	a_align_held: assert property (
		(evt_i.realign || (f_align && !rd_sds)) |=> f_align)
		else $error("realignment flag lost before read");

	a_pkt_flag: assert property (
		(good_inc || (f_pkt && !rd_good)) |=> f_pkt)
		else $error("packet flag lost before read");

	// A read with no error in the same cycle leaves zero
	a_crc_clear: assert property (
		(rd_crc && !crc_inc) |=> crc_cnt == '0)
		else $error("crc counter not cleared by read");

endmodule // mspc_status_counters

`default_nettype wire

// [tb/mspc_pcs_model.sv]
// Behavioural PCS and fiber link partner feeding the status bank
`timescale 1ns/1ps
`default_nettype none

module mspc_pcs_model (
	// Clock
	input  wire logic                 core_clk_i,
	// Toward the status bank
	output var  mspc_pkg::mspc_evt_t  evt_o,
	output var  mspc_pkg::mspc_lvl_t  lvl_o,
	output var  mspc_pkg::mspc_pkt_t  pkt_o,
	output logic [15:0]               cfg_word_o,
	output logic                      cfg_valid_o
);
	initial begin
		evt_o = '0;
		lvl_o = '0;
		lvl_o.comma_det = 1'b1;
		pkt_o = '0;
		cfg_word_o = 16'h0000;
		cfg_valid_o = 1'b0;
	end

	task automatic pulse(input mspc_pkg::mspc_evt_t e);
		@(posedge core_clk_i);
		evt_o <= e;
		@(posedge core_clk_i);
		evt_o <= '0;
	endtask

	task automatic set_lvl(input mspc_pkg::mspc_lvl_t l);
		@(posedge core_clk_i);
		lvl_o <= l;
	endtask

	// Word idles inverted so a stale value cannot pass for a latch
	task automatic send_word(input logic [15:0] w);
		@(posedge core_clk_i);
		cfg_word_o <= w;
		cfg_valid_o <= 1'b1;
		@(posedge core_clk_i);
		cfg_word_o <= ~w;
		cfg_valid_o <= 1'b0;
	endtask

	task automatic burst(input mspc_pkg::mspc_pkt_t p, input int n);
		repeat (n) begin
			@(posedge core_clk_i);
			pkt_o <= p;
		end
		@(posedge core_clk_i);
		pkt_o <= '0;
	endtask
endmodule // mspc_pcs_model

`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the PCS status and counter bank
`timescale 1ns/1ps
`default_nettype none
`include "mspc_defines.svh"

module tb;
	logic                core_clk_i;
	logic                rst_n_i;
	logic [4:0]          addr;
	logic [15:0]         wdata;
	logic                wr;
	logic                rd;
	logic [15:0]         rdata;
	logic [15:0]         adv_word;
	logic                force_adv;
	mspc_pkg::mspc_evt_t evt;
	mspc_pkg::mspc_evt_t e;
	mspc_pkg::mspc_lvl_t lvl;
	mspc_pkg::mspc_lvl_t lv;
	mspc_pkg::mspc_pkt_t pkt;
	logic [15:0]         cfg_word;
	logic                cfg_valid;
	logic [15:0]         v;
	logic [15:0]         w;
	logic [4:0]          a;
	int                  err_count;
	int                  checks;
	int                  seed;
	int                  i;
	int                  n;
	logic [4:0]  ofs [8] = '{5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h05};
	logic [15:0] rst [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1000, 16'h0, 16'h0, 16'h0};
	logic [15:0] stk [6] = '{16'h8000, 16'h4000, 16'h0800, 16'h8000, 16'h2000, 16'h0080};

	mspc_status_counters uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .evt_i(evt), .lvl_i(lvl),
		.pkt_i(pkt), .rx_cfg_word_i(cfg_word), .rx_cfg_valid_i(cfg_valid),
		.adv_word_o(adv_word), .force_adv_o(force_adv));
	mspc_pcs_model pcs (.core_clk_i(core_clk_i), .evt_o(evt), .lvl_o(lvl), .pkt_o(pkt),
		.cfg_word_o(cfg_word), .cfg_valid_o(cfg_valid));

	// ----------------------------------------
	// Expectations and bus tasks
	// ----------------------------------------
	function automatic logic [15:0] pcs_live(input logic [15:0] c, input mspc_pkg::mspc_lvl_t l);
		return {2'b00, l.pt_mode & l.pt_link_100, l.pt_mode & l.pt_link_10, 2'b00, c[13:12],
			c[8], c[7], c[5], c[6], l.partner_an_able, l.link_up, l.an_done, l.sig_det};
	endfunction

	function automatic logic [15:0] sds_live(input mspc_pkg::mspc_lvl_t l, input logic c);
		return {1'b0, l.sig_det, 1'b0, c, l.comma_pos, 8'h00};
	endfunction

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [4:0] ad, input logic [15:0] d);
		@(posedge core_clk_i);
		wr <= 1'b1;
		addr <= ad;
		wdata <= d;
		@(posedge core_clk_i);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [4:0] ad, output logic [15:0] d);
		@(posedge core_clk_i);
		rd <= 1'b1;
		addr <= ad;
		@(posedge core_clk_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic rd_chk(input logic [4:0] ad, input logic [15:0] exp);
		logic [15:0] d;
		rd_reg(ad, d);
		check($sformatf("reg 0x%0h", ad), d, exp);
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	// Bus never stalls, so only a broken run can reach this
	initial begin
		#400000;
		err_count++;
		end_of_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 50993;
		err_count = 0;
		checks = 0;
		rst_n_i = 1'b0;
		addr = 5'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		lv = '0;
		lv.comma_det = 1'b1;
		repeat (6) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		for (i = 0; i < 8; i++) rd_chk(ofs[i], rst[i]);
		w = 16'($random(seed));
		wr_reg(`MSPC_OFS_ADV, w);
		rd_chk(`MSPC_OFS_ADV, 16'h0000);
		wr_reg(`MSPC_OFS_CTRL, 16'hFFFF);
		check("force_adv_o", {15'h0000, force_adv}, 16'h0001);
		rd_chk(`MSPC_OFS_CTRL, 16'h0800);
		wr_reg(`MSPC_OFS_ADV, w);
		check("adv_word_o", adv_word, w);
		rd_chk(`MSPC_OFS_ADV, w);
		wr_reg(`MSPC_OFS_CTRL, 16'h0000);
		lv.pt_mode = 1'b1;
		pcs.set_lvl(lv);
		rd_chk(`MSPC_OFS_ADV, 16'h0000);
		for (i = 0; i < 8; i++) begin
			w = 16'($random(seed));
			lv = 12'($random(seed));
			{lv.pt_link_10, lv.pt_link_100, lv.pt_mode} = i[2:0];
			pcs.set_lvl(lv);
			pcs.send_word(w);
			rd_chk(`MSPC_OFS_PCS, pcs_live(w, lv));
			rd_chk(`MSPC_OFS_LP, w);
		end
		wr_reg(`MSPC_OFS_LP, ~w);
		rd_chk(`MSPC_OFS_LP, w);
		lv = '0;
		lv.comma_det = 1'b1;
		lv.comma_pos = 4'({$random(seed)} % 10);
		pcs.set_lvl(lv);
		rd_reg(`MSPC_OFS_SDS, v);
		rd_chk(`MSPC_OFS_SDS, sds_live(lv, 1'b1));
		for (i = 0; i < 6; i++) begin
			e = mspc_pkg::mspc_evt_t'(6'h20 >> i);
			a = (i < 3) ? `MSPC_OFS_PCS : `MSPC_OFS_SDS;
			v = (i < 3) ? pcs_live(w, lv) : sds_live(lv, 1'b1);
			pcs.pulse(e);
			rd_chk(a, v | stk[i]);
			rd_chk(a, v);
		end
		fork
			pcs.pulse(6'h20);
			rd_reg(`MSPC_OFS_PCS, v);
		join
		check("sync race read", v, pcs_live(w, lv));
		rd_chk(`MSPC_OFS_PCS, pcs_live(w, lv) | 16'h8000);
		lv.sig_det = 1'b1;
		lv.comma_det = 1'b0;
		pcs.set_lvl(lv);
		lv.sig_det = 1'b0;
		lv.comma_det = 1'b1;
		pcs.set_lvl(lv);
		rd_chk(`MSPC_OFS_SDS, sds_live(lv, 1'b0) | 16'h4000);
		rd_chk(`MSPC_OFS_SDS, sds_live(lv, 1'b1));
		lv.link_up = 1'b1;
		pcs.set_lvl(lv);
		n = 1 + {$random(seed)} % 20;
		pcs.burst(4'hA, n);
		rd_chk(`MSPC_OFS_GOOD, 16'h8000 | 16'(n));
		rd_chk(`MSPC_OFS_GOOD, 16'(n));
		wr_reg(`MSPC_OFS_CRC, 16'h7FFF);
		rd_chk(`MSPC_OFS_CRC, 16'h4000);
		pcs.burst(4'h1, 300);
		rd_chk(`MSPC_OFS_CRC, 16'h40FF);
		pcs.burst(4'h5, 3);
		rd_chk(`MSPC_OFS_CRC, 16'h4003);
		lv.link_up = 1'b0;
		pcs.set_lvl(lv);
		pcs.burst(4'hF, 7);
		rd_chk(`MSPC_OFS_CRC, 16'h4000);
		rd_chk(`MSPC_OFS_GOOD, 16'(n));
		wr_reg(`MSPC_OFS_CRC, 16'h8000);
		lv.link_up = 1'b1;
		pcs.set_lvl(lv);
		pcs.burst(4'hF, 4);
		rd_chk(`MSPC_OFS_CRC, 16'h8000);
		rd_chk(`MSPC_OFS_GOOD, 16'(n));
		wr_reg(`MSPC_OFS_CRC, 16'h0000);
		pcs.burst(4'h8, 10000 - n);
		rd_chk(`MSPC_OFS_GOOD, 16'h8000);
		end_of_test();
	end
endmodule // tb

`default_nettype wire
